// ### rtl/system_exception_control.sv
// Exception control registers: grouping, reset controls, handler priorities
// and handler enable, pending and active state, with an event interrupt.
// Assumes a classic Wishbone master on clk_i and fault strobes from the core.
//
// Overview of operation
// - The grouping selector at bits 10-8 splits each priority into pre-emption and sub parts, 000 giving one sub bit and 111 none pre-emption.
// - Each system exception owns one eight-bit priority slot, four slots to a word.
// - Only the top three bits of each slot hold a priority.
// - Unimplemented priority bits read zero and ignore writes.
// - The first priority word holds memory fault at 7-5, bus fault at 15-13, usage fault at 23-21 and a reserved slot at 31-29.
// - The priority words sit at 0xE000_ED18, 0xE000_ED1C and 0xE000_ED20 with slots 4-7, 8-11 and 12-15.
// - Writing one to bit 2 raises the system reset request output.
// - The system reset request causes a warm reset that also clears the request bit.
// - Writing one to the clear-active bit erases all active state and the bit self-clears, zero doing nothing.
// - Writing one to bit 0 resets the system except debug units and the bit self-clears.
// - Little-endian is the default data format.
// - Enables sit at bits 18-16 and pending flags at bits 15-12.
// - Active flags sit at bits 11, 10, 8, 7, 3, 1 and 0, others reading zero.
// - Writes to the reset control take effect only with key 0x5FA and the key field reads 0xFA05.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module system_exception_control
	import exc_ctrl_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	input  wire logic        usage_fault_i,
	input  wire logic        bus_fault_i,
	input  wire logic        memory_fault_i,
	input  wire logic [2:0]  fault_prio_sel_i,
	output logic      [7:0]  fault_preempt_o,
	output logic      [7:0]  fault_sub_o,
	output logic             system_reset_request_o,
	output logic             local_system_reset_o,
	output logic             clear_active_state_o,
	output logic             hard_fault_o,
	output logic             endian_big_o,
	output logic             irq_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	bus_state_e  bus_q;
	logic [31:0] prio_fault_q;
	logic [31:0] prio_svc_q;
	logic [31:0] prio_tick_q;
	logic [31:0] hctrl_q;
	logic [2:0]  split_q;
	logic        endian_q;
	logic        sys_reset_req_q;
	logic        local_reset_q;
	logic        clr_active_q;
	logic [EVT_COUNT-1:0] evt_status_q;
	logic [EVT_COUNT-1:0] evt_enable_q;
	logic        hard_fault_q;
	logic [7:0]  preempt_q;
	logic [7:0]  sub_q;
	logic [31:0] dat_q;

	logic        req;
	logic        wr;
	logic        key_ok;
	logic [31:0] wmask;
	logic [7:0]  preempt_w;
	logic [7:0]  sub_w;
	logic [2:0]  sel_prio;
	logic [EVT_COUNT-1:0] evt_set;
	logic        escalate;

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
					      input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
		hit = (a[31:2] == base[31:2]);
	endfunction

	// Request is taken once per access; the idle gap keeps it from repeating.
	assign req   = cyc_i && stb_i && (bus_q == BUS_IDLE);
	assign wr    = req && we_i;
	assign wmask = lane_mask(sel_i);
	assign key_ok = (dat_i[31:KEY_LSB] == WRITE_KEY) && (sel_i[3:2] == 2'b11);

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_q <= BUS_IDLE;
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else if (req) begin
			bus_q <= BUS_ACK;
			ack_o <= !err_q_next();
			err_o <= err_q_next();
		end else begin
			bus_q <= BUS_IDLE;
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end
	end

	function automatic logic err_q_next();
		err_q_next = !(hit(adr_i, RESET_CTRL_ADDR) || hit(adr_i, FAULT_PRIO_ADDR) ||
			       hit(adr_i, SVC_PRIO_ADDR) || hit(adr_i, TICK_PRIO_ADDR) ||
			       hit(adr_i, HANDLER_CTRL_ADDR) || hit(adr_i, EVT_STATUS_ADDR) ||
			       hit(adr_i, EVT_CLEAR_ADDR) || hit(adr_i, EVT_ENABLE_ADDR));
	endfunction

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h00000000;
		end else if (req && !we_i) begin
			if (hit(adr_i, RESET_CTRL_ADDR)) begin
				dat_q <= {KEY_READBACK, endian_q, 4'h0, split_q, 5'h00,
					  sys_reset_req_q, 2'b00};
			end else if (hit(adr_i, FAULT_PRIO_ADDR)) begin
				dat_q <= prio_fault_q & PRIO_MASK;
			end else if (hit(adr_i, SVC_PRIO_ADDR)) begin
				dat_q <= prio_svc_q & PRIO_MASK;
			end else if (hit(adr_i, TICK_PRIO_ADDR)) begin
				dat_q <= prio_tick_q & PRIO_MASK;
			end else if (hit(adr_i, HANDLER_CTRL_ADDR)) begin
				dat_q <= hctrl_q & HCTRL_MASK;
			end else if (hit(adr_i, EVT_STATUS_ADDR)) begin
				dat_q <= {28'h0000000, evt_status_q};
			end else if (hit(adr_i, EVT_ENABLE_ADDR)) begin
				dat_q <= {28'h0000000, evt_enable_q};
			end else begin
				dat_q <= 32'h00000000;
			end
		end
	end
	assign dat_o = dat_q;

	// ----------------------------------------
	// Reset and grouping control
	// ----------------------------------------
	// The request bit is cleared only by the warm reset it triggers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			split_q         <= SPLIT_RESET;
			endian_q        <= ENDIAN_RESET;
			sys_reset_req_q <= 1'b0;
		end else if (wr && hit(adr_i, RESET_CTRL_ADDR) && key_ok) begin
			if (sel_i[1]) begin
				split_q  <= dat_i[SPLIT_LSB+2:SPLIT_LSB];
				endian_q <= dat_i[ENDIAN_BIT];
			end
			if (sel_i[0] && dat_i[SYS_RESET_BIT]) begin
				sys_reset_req_q <= 1'b1;
			end
		end
	end

	// Self-clearing pulses last one cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			local_reset_q <= 1'b0;
			clr_active_q  <= 1'b0;
		end else begin
			local_reset_q <= wr && hit(adr_i, RESET_CTRL_ADDR) && key_ok && sel_i[0] &&
					 dat_i[LOCAL_RESET_BIT];
			clr_active_q  <= wr && hit(adr_i, RESET_CTRL_ADDR) && key_ok && sel_i[0] &&
					 dat_i[CLR_ACTIVE_BIT];
		end
	end

	// ----------------------------------------
	// Priority words
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prio_fault_q <= PRIO_RESET;
			prio_svc_q   <= PRIO_RESET;
			prio_tick_q  <= PRIO_RESET;
		end else if (wr) begin
			if (hit(adr_i, FAULT_PRIO_ADDR)) begin
				prio_fault_q <= merge(prio_fault_q, dat_i, wmask & PRIO_MASK);
			end else if (hit(adr_i, SVC_PRIO_ADDR)) begin
				prio_svc_q <= merge(prio_svc_q, dat_i, wmask & PRIO_MASK);
			end else if (hit(adr_i, TICK_PRIO_ADDR)) begin
				prio_tick_q <= merge(prio_tick_q, dat_i, wmask & PRIO_MASK);
			end
		end
	end

	// Slot index from the fault selector: 0 memory, 1 bus, 2 usage, 3 reserved.
	always_comb begin
		sel_prio = prio_fault_q[fault_prio_sel_i[1:0]*SLOT_BITS+5 +: PRIO_BITS];
	end

	prio_split u_split (
		.split_i   (split_q),
		.prio_i    (sel_prio),
		.preempt_o (preempt_w),
		.sub_o     (sub_w)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			preempt_q <= 8'h00;
			sub_q     <= 8'h00;
		end else begin
			preempt_q <= preempt_w;
			sub_q     <= sub_w;
		end
	end

	// ----------------------------------------
	// Handler control and state
	// ----------------------------------------
	assign escalate = (usage_fault_i && !hctrl_q[USG_ENA_BIT]) ||
			  (bus_fault_i && !hctrl_q[BUS_ENA_BIT]) ||
			  (memory_fault_i && !hctrl_q[MEM_ENA_BIT]);

	// Hardware pending sets win over a software write in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hctrl_q <= HCTRL_RESET;
		end else begin
			if (wr && hit(adr_i, HANDLER_CTRL_ADDR)) begin
				hctrl_q <= merge(hctrl_q, dat_i, wmask & HCTRL_MASK);
			end
			if (clr_active_q) begin
				hctrl_q <= hctrl_q & ~ACTIVE_MASK;
			end
			if (usage_fault_i && hctrl_q[USG_ENA_BIT]) begin
				hctrl_q[USG_PEND_BIT] <= 1'b1;
			end
			if (bus_fault_i && hctrl_q[BUS_ENA_BIT]) begin
				hctrl_q[BUS_PEND_BIT] <= 1'b1;
			end
			if (memory_fault_i && hctrl_q[MEM_ENA_BIT]) begin
				hctrl_q[MEM_PEND_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hard_fault_q <= 1'b0;
		end else begin
			hard_fault_q <= escalate;
		end
	end

	// ----------------------------------------
	// Event status and interrupt
	// ----------------------------------------
	assign evt_set = {hard_fault_q, clr_active_q, local_reset_q, sys_reset_req_q};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_status_q <= EVT_RESET;
			evt_enable_q <= EVT_RESET;
		end else begin
			if (wr && hit(adr_i, EVT_ENABLE_ADDR) && sel_i[0]) begin
				evt_enable_q <= dat_i[EVT_COUNT-1:0];
			end
			if (wr && hit(adr_i, EVT_CLEAR_ADDR) && sel_i[0]) begin
				evt_status_q <= (evt_status_q & ~dat_i[EVT_COUNT-1:0]) | evt_set;
			end else begin
				evt_status_q <= evt_status_q | evt_set;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(evt_status_q & evt_enable_q);
		end
	end

	assign system_reset_request_o = sys_reset_req_q;
	assign local_system_reset_o   = local_reset_q;
	assign clear_active_state_o   = clr_active_q;
	assign hard_fault_o           = hard_fault_q;
	assign endian_big_o           = endian_q;
	assign fault_preempt_o        = preempt_q;
	assign fault_sub_o            = sub_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_keyed_reset_write;
		wr && hit(adr_i, RESET_CTRL_ADDR) && key_ok && sel_i[0];
	endsequence

	a_sysreq_set: assert property (@(posedge clk_i) disable iff (rst_i)
		s_keyed_reset_write ##0 dat_i[SYS_RESET_BIT] |=> system_reset_request_o)
		else $error("reset request not raised");
	a_sysreq_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		system_reset_request_o |=> system_reset_request_o)
		else $error("reset request dropped without reset");
	a_clr_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		clear_active_state_o |=> !clear_active_state_o)
		else $error("clear active did not self clear");
	a_clr_effect: assert property (@(posedge clk_i) disable iff (rst_i)
		clear_active_state_o |=> ((hctrl_q & ACTIVE_MASK) == 32'h00000000))
		else $error("active flags survived clear");
	a_local_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		s_keyed_reset_write ##0 dat_i[LOCAL_RESET_BIT] |=> local_system_reset_o)
		else $error("local reset not pulsed");
	a_key_block: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit(adr_i, RESET_CTRL_ADDR) && !key_ok |=> $stable(split_q))
		else $error("unkeyed write changed grouping");
	a_prio_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(prio_fault_q & ~PRIO_MASK) == 32'h00000000)
		else $error("unimplemented priority bit set");
	a_hctrl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(hctrl_q & ~HCTRL_MASK) == 32'h00000000)
		else $error("reserved control bit set");
	a_escalate: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_fault_i && !hctrl_q[BUS_ENA_BIT] |=> hard_fault_o)
		else $error("disabled fault not escalated");
	a_pend_set: assert property (@(posedge clk_i) disable iff (rst_i)
		usage_fault_i && hctrl_q[USG_ENA_BIT] |=> hctrl_q[USG_PEND_BIT])
		else $error("enabled fault not pended");
	a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> (ack_o || err_o) ##1 !(ack_o || err_o))
		else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// ### rtl/exc_ctrl_pkg.sv
// Constants shared by the exception control register block.
// Assumes a 32-bit classic Wishbone slave decoding word addresses.
package exc_ctrl_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [31:0] RESET_CTRL_ADDR    = 32'hE000ED0C;
	localparam logic [31:0] FAULT_PRIO_ADDR    = 32'hE000ED18;
	localparam logic [31:0] SVC_PRIO_ADDR      = 32'hE000ED1C;
	localparam logic [31:0] TICK_PRIO_ADDR     = 32'hE000ED20;
	localparam logic [31:0] HANDLER_CTRL_ADDR  = 32'hE000ED24;
	localparam logic [31:0] EVT_STATUS_ADDR    = 32'hE000ED80;
	localparam logic [31:0] EVT_CLEAR_ADDR     = 32'hE000ED84;
	localparam logic [31:0] EVT_ENABLE_ADDR    = 32'hE000ED88;

	// ----------------------------------------
	// Reset and grouping control fields
	// ----------------------------------------
	localparam logic [15:0] WRITE_KEY          = 16'h05FA;
	localparam logic [15:0] KEY_READBACK       = 16'hFA05;
	localparam int          KEY_LSB            = 16;
	localparam int          ENDIAN_BIT         = 15;
	localparam int          SPLIT_LSB          = 8;
	localparam int          SYS_RESET_BIT      = 2;
	localparam int          CLR_ACTIVE_BIT     = 1;
	localparam int          LOCAL_RESET_BIT    = 0;
	localparam logic        ENDIAN_RESET       = 1'b0;
	localparam logic [2:0]  SPLIT_RESET        = 3'h0;

	// ----------------------------------------
	// Priority slots
	// ----------------------------------------
	localparam int          SLOT_BITS          = 8;
	localparam int          PRIO_BITS          = 3;
	localparam logic [31:0] PRIO_MASK          = 32'hE0E0E0E0;
	localparam logic [31:0] PRIO_RESET         = 32'h00000000;

	// ----------------------------------------
	// Handler control and state fields
	// ----------------------------------------
	localparam int          USG_ENA_BIT        = 18;
	localparam int          BUS_ENA_BIT        = 17;
	localparam int          MEM_ENA_BIT        = 16;
	localparam int          SVC_PEND_BIT       = 15;
	localparam int          BUS_PEND_BIT       = 14;
	localparam int          MEM_PEND_BIT       = 13;
	localparam int          USG_PEND_BIT       = 12;
	localparam logic [31:0] HCTRL_MASK         = 32'h0007FD8B;
	localparam logic [31:0] ACTIVE_MASK        = 32'h00000D8B;
	localparam logic [31:0] HCTRL_RESET        = 32'h00000000;
	localparam int          TICK_ACT_BIT       = 11;
	localparam int          PSV_ACT_BIT        = 10;
	localparam int          MON_ACT_BIT        = 8;
	localparam int          SVC_ACT_BIT        = 7;
	localparam int          USG_ACT_BIT        = 3;
	localparam int          BUS_ACT_BIT        = 1;
	localparam int          MEM_ACT_BIT        = 0;

	// ----------------------------------------
	// Event status bits
	// ----------------------------------------
	localparam int          EVT_COUNT          = 4;
	localparam int          EVT_SYS_RESET      = 0;
	localparam int          EVT_LOCAL_RESET    = 1;
	localparam int          EVT_CLR_ACTIVE     = 2;
	localparam int          EVT_ESCALATE       = 3;
	localparam logic [3:0]  EVT_RESET          = 4'h0;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_state_e;

endpackage

// ### rtl/prio_split.sv
// Splits a three-bit priority held in the top of an eight-bit slot into
// pre-emption and sub-priority parts under the grouping selector.
// Assumes same-clock inputs; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module prio_split (
	input  wire logic [2:0] split_i,
	input  wire logic [2:0] prio_i,
	output logic      [7:0] preempt_o,
	output logic      [7:0] sub_o
);
	logic [7:0] slot;
	logic [7:0] sub_mask;

	// Selector n leaves n+1 low bits as sub-priority; 7 leaves none for pre-emption.
	always_comb begin
		slot      = {prio_i, 5'h00};
		sub_mask  = 8'hFF >> (3'h7 - split_i);
		preempt_o = slot & ~sub_mask;
		sub_o     = slot & sub_mask;
	end
endmodule
`default_nettype wire

// ### test/core_fault_model.sv
// Core-side fault source that faces the exception control block.
// Assumes it shares clk_i with the block and is steered by the bench.
`timescale 1ns/1ps
`default_nettype none
module core_fault_model (
	input  wire logic clk_i,
	output logic      usage_fault_o,
	output logic      bus_fault_o,
	output logic      memory_fault_o
);
	// ----------------------------------------
	// Fault strobes
	// ----------------------------------------
	// The core never edits the active flags and never repairs stacked context.
	initial begin
		usage_fault_o  = 1'b0;
		bus_fault_o    = 1'b0;
		memory_fault_o = 1'b0;
	end

	// One strobe for one cycle, since every high cycle counts as a new fault.
	task automatic strobe(input logic [1:0] kind);
		@(posedge clk_i);
		usage_fault_o  <= (kind == 2'h0);
		bus_fault_o    <= (kind == 2'h1);
		memory_fault_o <= (kind == 2'h2);
		@(posedge clk_i);
		usage_fault_o  <= 1'b0;
		bus_fault_o    <= 1'b0;
		memory_fault_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### test/system_exception_control_tb_top.sv
// Self-checking bench for the exception control block.
// Assumes a classic Wishbone register bus and a core fault model on one clock.
`timescale 1ns/1ps
`default_nettype none
module system_exception_control_tb_top
	import exc_ctrl_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [31:0] adr_i;
	logic [31:0] dat_i;
	logic [3:0]  sel_i;
	logic [2:0]  fault_prio_sel_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        err_o;
	logic        usg_f;
	logic        bus_f;
	logic        mem_f;
	logic [7:0]  pre;
	logic [7:0]  sub;
	logic        sysreq;
	logic        lrst;
	logic        clra;
	logic        hf;
	logic        endian;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          n_fail;
	int          checks;
	int          n_lrst;
	int          n_clra;
	int          n_hf;
	int          n0;
	localparam logic [31:0] KEYED = {WRITE_KEY, 16'h0000};
	localparam logic [31:0] READK = {KEY_READBACK, 16'h0000};

	system_exception_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.usage_fault_i(usg_f), .bus_fault_i(bus_f), .memory_fault_i(mem_f), .fault_prio_sel_i(fault_prio_sel_i),
		.fault_preempt_o(pre), .fault_sub_o(sub), .system_reset_request_o(sysreq), .local_system_reset_o(lrst),
		.clear_active_state_o(clra), .hard_fault_o(hf), .endian_big_o(endian), .irq_o(irq));
	core_fault_model core_u (.clk_i(clk_i), .usage_fault_o(usg_f), .bus_fault_o(bus_f), .memory_fault_o(mem_f));

	// ----------------------------------------
	// Clock, pulse counters and watchdog
	// ----------------------------------------
	always #4 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (lrst === 1'b1) n_lrst++;
		if (clra === 1'b1) n_clra++;
		if (hf === 1'b1) n_hf++;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		report_and_stop();
	end

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask

	// The answer is taken at the rising edge where ack or err is seen high, and the request drops there.
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
		rd = dat_o;
		er = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			report_and_stop();
		end
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	task automatic report_and_stop();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		rdchk(FAULT_PRIO_ADDR, PRIO_RESET);
		rdchk(HANDLER_CTRL_ADDR, HCTRL_RESET);
		rdchk(RESET_CTRL_ADDR, READK);
		chk({31'h0, endian}, 32'h00000000);
		$display("reset values done");
	endtask

	task automatic t_prio_words();
		logic [31:0] adrs [3];
		adrs = '{FAULT_PRIO_ADDR, SVC_PRIO_ADDR, TICK_PRIO_ADDR};
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, adrs[i], 32'hFFFFFFFF);
			rdchk(adrs[i], PRIO_MASK);
			wb(1'b1, adrs[i], 32'h3F5F7F9F);
			rdchk(adrs[i], 32'h20406080);
		end
		wb(1'b1, 32'hE000ED28, 32'h00000000);
		chk({31'h0, er}, 32'h00000001);
		$display("priority words done");
	endtask

	// Slot value A0 has bits 7 and 5 set; selector s leaves its s+1 low bits to the sub part.
	task automatic t_split();
		wb(1'b1, FAULT_PRIO_ADDR, 32'h000000A0);
		fault_prio_sel_i <= 3'h0;
		for (int s = 0; s < 8; s++) begin
			wb(1'b1, RESET_CTRL_ADDR, KEYED | (32'(s) << SPLIT_LSB));
			settle();
			chk({24'h0, pre}, (32'h000000A0 >> (s + 1)) << (s + 1));
			chk({24'h0, sub}, 32'h000000A0 - ((32'h000000A0 >> (s + 1)) << (s + 1)));
			rdchk(RESET_CTRL_ADDR, READK | (32'(s) << SPLIT_LSB));
		end
		wb(1'b1, RESET_CTRL_ADDR, 32'h12340300);
		rdchk(RESET_CTRL_ADDR, READK | 32'h00000700);
		wb(1'b1, FAULT_PRIO_ADDR, 32'hE0C0A000);
		for (int k = 1; k < 4; k++) begin
			@(posedge clk_i);
			fault_prio_sel_i <= 3'(k);
			settle();
			chk({24'h0, sub}, 32'h00000080 + 32'(k) * 32'h00000020);
		end
		$display("grouping done");
	endtask

	task automatic t_reset_request();
		wb(1'b1, EVT_ENABLE_ADDR, 32'h00000001);
		wb(1'b1, RESET_CTRL_ADDR, KEYED | 32'h00000004);
		settle();
		chk({31'h0, sysreq}, 32'h00000001);
		chk({31'h0, irq}, 32'h00000001);
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({31'h0, sysreq}, 32'h00000000);
		rdchk(RESET_CTRL_ADDR, READK);
		$display("reset request done");
	endtask

	task automatic t_local_and_clear();
		n0 = n_lrst;
		wb(1'b1, RESET_CTRL_ADDR, KEYED | 32'h00000001);
		settle();
		chk(32'(n_lrst - n0), 32'h00000001);
		rdchk(RESET_CTRL_ADDR, READK);
		wb(1'b1, HANDLER_CTRL_ADDR, 32'hFFFFFFFF);
		rdchk(HANDLER_CTRL_ADDR, HCTRL_MASK);
		wb(1'b1, RESET_CTRL_ADDR, KEYED);
		rdchk(HANDLER_CTRL_ADDR, HCTRL_MASK);
		n0 = n_clra;
		wb(1'b1, RESET_CTRL_ADDR, KEYED | 32'h00000002);
		settle();
		chk(32'(n_clra - n0), 32'h00000001);
		rdchk(HANDLER_CTRL_ADDR, HCTRL_MASK & ~ACTIVE_MASK);
		rdchk(RESET_CTRL_ADDR, READK);
		$display("local reset and clear active done");
	endtask

	task automatic t_escalate();
		wb(1'b1, HANDLER_CTRL_ADDR, 32'h00000000);
		wb(1'b1, EVT_CLEAR_ADDR, 32'h0000000F);
		wb(1'b1, EVT_ENABLE_ADDR, 32'h00000008);
		n0 = n_hf;
		core_u.strobe(2'h0);
		settle();
		chk(32'(n_hf - n0), 32'h00000001);
		chk({31'h0, irq}, 32'h00000001);
		rdchk(EVT_STATUS_ADDR, 32'h00000008);
		core_u.strobe(2'h1);
		settle();
		chk(32'(n_hf - n0), 32'h00000002);
		wb(1'b1, HANDLER_CTRL_ADDR, 32'h00070000);
		core_u.strobe(2'h0);
		core_u.strobe(2'h1);
		core_u.strobe(2'h2);
		settle();
		chk(32'(n_hf - n0), 32'h00000002);
		rdchk(HANDLER_CTRL_ADDR, 32'h00077000);
		wb(1'b1, EVT_ENABLE_ADDR, 32'h00000000);
		settle();
		chk({31'h0, irq}, 32'h00000000);
		wb(1'b1, EVT_STATUS_ADDR, 32'h00000000);
		rdchk(EVT_STATUS_ADDR, 32'h00000008);
		wb(1'b1, EVT_CLEAR_ADDR, 32'h00000008);
		rdchk(EVT_STATUS_ADDR, 32'h00000000);
		$display("escalation and interrupt done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 32'h00000000;
		dat_i = 32'h00000000;
		sel_i = 4'h0;
		fault_prio_sel_i = 3'h0;
		n_fail = 0;
		checks = 0;
		n_lrst = 0;
		n_clra = 0;
		n_hf = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_values();
		t_prio_words();
		t_split();
		t_reset_request();
		t_local_and_clear();
		t_escalate();
		report_and_stop();
	end
endmodule
`default_nettype wire
